//--- shared/mcs_regs.svh
// register offsets, field positions, reset values and timing counts of the clock select block
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH

// register indices as printed; byte address is four times the index
`define MCS_IDX_WAKEUP_FLAGS   10'h0a0
`define MCS_IDX_CLOCK_SELECT   10'h0a5
`define MCS_IDX_IRQ_STATUS     10'h0b0
`define MCS_IDX_IRQ_ENABLE     10'h0b1
`define MCS_IDX_IRQ_CLEAR      10'h0b2

// reset values
`define MCS_RST_WAKEUP_FLAGS   8'h00
`define MCS_RST_CLOCK_SELECT   8'h40
`define MCS_RST_IRQ_ENABLE     5'h00

// clock select fields
`define MCS_BIT_SLEEP          7
`define MCS_BIT_RING_EN        6
`define MCS_BIT_OVERRIDE       5
`define MCS_BIT_RATE_HI        4
`define MCS_BIT_RATE_LO        3
`define MCS_BIT_STABLE         2

// wakeup flag fields
`define MCS_BIT_BUS_RESET      2
`define MCS_BIT_RESUME         1
`define MCS_BIT_EXTERNAL       0

// single-ended zero length in bit times before bus reset is flagged
`define MCS_SE0_FULL_BITS      7'h20
`define MCS_SE0_LOW_BITS       7'h04

// source edges spent on each side of a clock handover
`define MCS_SWITCH_EDGES       2'h3

// setup nak window after bus reset release
`define MCS_HCLK_MHZ           25
`define MCS_NAK_WINDOW_MS      10
`define MCS_NAK_WINDOW_CYCLES  (`MCS_NAK_WINDOW_MS * 1000 * `MCS_HCLK_MHZ)

`endif

//--- shared/mcs_pkg.sv
// types shared by the clock select and wakeup logic
package mcs_pkg;
  // glitch-free switch progress
  typedef enum logic [1:0] {
    follow,
    drain_old,
    fill_new
  } mcs_switch_state_type;
  // oscillator shutdown progress
  typedef enum logic [1:0] {
    awake,
    ring_gated,
    all_off
  } mcs_sleep_state_type;
endpackage

//--- verilog/mcs_rate_divider.sv
// divides the crystal-derived edge pulses down to the selected rate
`timescale 1ns/1ps
`default_nettype none
module mcs_rate_divider (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       in_tick,
  input  wire logic [1:0] rate_sel,
  output logic            out_tick
);
  logic [2:0] div_cnt;  // counts crystal edges

  // free running edge counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 3'h0;
    end else if (in_tick) begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  // rate decode, 11 every edge down to 00 every eighth
  always_comb begin
    case (rate_sel)
      2'h3:    out_tick = in_tick;
      2'h2:    out_tick = in_tick & (div_cnt[0] == 1'b0);
      2'h1:    out_tick = in_tick & (div_cnt[1:0] == 2'h0);
      default: out_tick = in_tick & (div_cnt == 3'h0);
    endcase
  end

  property p_full_rate;
    @(posedge hclk) disable iff (!hresetn)
    (rate_sel == 2'h3 && in_tick) |-> out_tick;
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("fastest rate dropped an edge");
endmodule // mcs_rate_divider
`default_nettype wire

//--- verilog/mcs_clock_switch.sv
// glitch-free handover of the core clock between ring and crystal edges
`timescale 1ns/1ps
`default_nettype none
`include "mcs_regs.svh"
module mcs_clock_switch (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ring_tick,
  input  wire logic crystal_tick,
  input  wire logic want_crystal,
  output logic      mcu_clk,
  output logic      switching,
  output logic      switch_done
);
  mcs_pkg::mcs_switch_state_type state;  // handover progress
  logic       cur_crystal;               // source now driving the output
  logic [1:0] edge_cnt;                  // edges seen in this handover step
  logic       old_tick;
  logic       new_tick;

  assign old_tick  = cur_crystal ? crystal_tick : ring_tick;
  assign new_tick  = cur_crystal ? ring_tick : crystal_tick;
  assign switching = (state != mcs_pkg::follow);

  // three old edges then three new edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state       <= mcs_pkg::follow;
      cur_crystal <= 1'b0;
      edge_cnt    <= 2'h0;
      switch_done <= 1'b0;
    end else begin
      switch_done <= 1'b0;
      case (state)
        mcs_pkg::follow: begin
          // a new request starts the drain of the old source
          if (want_crystal != cur_crystal) begin
            state    <= mcs_pkg::drain_old;
            edge_cnt <= 2'h0;
          end
        end
        mcs_pkg::drain_old: begin
          if (old_tick) begin
            if (edge_cnt == `MCS_SWITCH_EDGES - 2'h1) begin
              state    <= mcs_pkg::fill_new;
              edge_cnt <= 2'h0;
            end else begin
              edge_cnt <= edge_cnt + 2'h1;
            end
          end
        end
        mcs_pkg::fill_new: begin
          if (new_tick) begin
            if (edge_cnt == `MCS_SWITCH_EDGES - 2'h1) begin
              state       <= mcs_pkg::follow;
              cur_crystal <= ~cur_crystal;
              switch_done <= 1'b1;
            end else begin
              edge_cnt <= edge_cnt + 2'h1;
            end
          end
        end
        default: state <= mcs_pkg::follow;
      endcase
    end
  end

  // output held low while handing over
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mcu_clk <= 1'b0;
    end else if (state != mcs_pkg::follow) begin
      mcu_clk <= 1'b0;
    end else if (old_tick) begin
      mcu_clk <= ~mcu_clk;
    end
  end

  // last new edge ends the handover
  property p_switch_bound;
    @(posedge hclk) disable iff (!hresetn)
    (state == mcs_pkg::fill_new && new_tick && edge_cnt == 2'h2) |=> (state == mcs_pkg::follow) && switch_done;
  endproperty
  a_switch_bound: assert property (p_switch_bound) else $error("handover overran six edges");

  property p_no_runt;
    @(posedge hclk) disable iff (!hresetn)
    (state != mcs_pkg::follow && $past(state) != mcs_pkg::follow) |-> !mcu_clk;
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("clock pulse during handover");
endmodule // mcs_clock_switch
`default_nettype wire

//--- verilog/mcs_clock_select_wakeup.sv
// core clock source select, sleep control and wakeup flags behind an ahb-lite slave
//
// Behaviour
// - sleep with power-down gates ring, then all
// - bit 6 enables ring oscillator, reset on
// - override zero runs core from ring
// - rate field picks 3.75 to 30 MHz
// - bit 2 mirrors phy clock valid; 1:0 zero
// - handover done in three plus three edges
// - long single-ended zero sets bus reset flag
// - setup naks allowed 10ms after reset
// - leaving idle during suspend sets resume flag
// - external flag follows disk or pin interrupt
// - writing one clears flags 1 and 2
// - unmasked wakeup restarts the crystal, and the ring if bit 6 enables it
// - enabled wakeup events drive wakeup interrupt
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mcs_regs.svh"
module mcs_clock_select_wakeup #(
  parameter int NAK_WINDOW_CYCLES = `MCS_NAK_WINDOW_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // core and phy status
  input  wire logic        core_power_control,
  input  wire logic        phy_clocks_stable,
  input  wire logic [2:0]  wakeup_mask_reg,
  input  wire logic        disk_interrupt_flag,
  input  wire logic        pin_interrupt_line,
  // bus line conditions from the serial interface engine
  input  wire logic        se0_level,
  input  wire logic        bit_tick,
  input  wire logic        low_speed,
  input  wire logic        line_state_j,
  input  wire logic        global_suspend,
  // oscillator edges
  input  wire logic        ring_osc_tick,
  input  wire logic        crystal_tick,
  // outputs
  output logic             ring_osc_run,
  output logic             crystal_osc_run,
  output logic             mcu_clk,
  output logic             setup_nak_window,
  output logic             wakeup_interrupt_input,
  output logic             irq
);
  // reset images, single fields picked out at reset
  localparam logic [7:0] CLK_SEL_RESET = `MCS_RST_CLOCK_SELECT;
  localparam logic [7:0] WAKE_RESET    = `MCS_RST_WAKEUP_FLAGS;
  // clock select fields
  logic       sleep_req;           // sleep bit
  logic       ring_osc_enable;     // ring oscillator enable
  logic       source_override;     // 1 = crystal rate, 0 = ring
  logic [1:0] rate_sel;            // crystal rate field
  // wakeup flags
  logic [4:0] wake_spare;          // reserved read/write bits 7:3
  logic       bus_reset_flag;
  logic       resume_flag;
  logic       external_event_flag;
  logic [2:0] wake_flags;
  logic       wake_any;
  // bus reset and resume detection
  logic [6:0] se0_cnt;             // bit times of single-ended zero
  logic [6:0] se0_need;            // threshold for current speed
  logic       reset_event;
  logic       reset_seen;          // long se0 still present
  logic [31:0] nak_cnt;            // nak window countdown
  logic       j_prev;
  logic       resume_event;
  logic       ext_prev;
  logic       stable_prev;
  // sleep control
  mcs_pkg::mcs_sleep_state_type sleep_state;
  // clock path
  logic       ring_gated_tick;
  logic       crystal_gated_tick;
  logic       rate_tick;
  logic       switch_done;
  logic       switching;
  // interrupt registers
  logic [4:0] irq_status;
  logic [4:0] irq_enable;
  logic [4:0] irq_events;
  // bus data phase
  logic       addr_ok;
  logic       wr_pend;
  logic [9:0] wr_index;
  logic       wr_clk;
  logic       wr_wake;
  logic       wr_ien;
  logic       wr_iclr;

  // register index decode
  function automatic logic is_index(input logic [9:0] idx, input logic [9:0] want);
    is_index = (idx == want);
  endfunction

  // ahb-lite answers at once, never an error
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel & hready & htrans[1];

  // capture of a write address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend  <= 1'b0;
      wr_index <= 10'h000;
    end else if (hready) begin
      wr_pend  <= addr_ok & hwrite & (hsize == 3'h2);
      wr_index <= haddr[11:2];
    end
  end

  assign wr_clk  = wr_pend & is_index(wr_index, `MCS_IDX_CLOCK_SELECT);
  assign wr_wake = wr_pend & is_index(wr_index, `MCS_IDX_WAKEUP_FLAGS);
  assign wr_ien  = wr_pend & is_index(wr_index, `MCS_IDX_IRQ_ENABLE);
  assign wr_iclr = wr_pend & is_index(wr_index, `MCS_IDX_IRQ_CLEAR);

  // read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      // stable bit mirrored, low bits zero
      if (is_index(haddr[11:2], `MCS_IDX_CLOCK_SELECT)) begin
        hrdata <= {24'h000000, sleep_req, ring_osc_enable, source_override, rate_sel, phy_clocks_stable, 2'h0};
      end else if (is_index(haddr[11:2], `MCS_IDX_WAKEUP_FLAGS)) begin
        hrdata <= {24'h000000, wake_spare, wake_flags};
      end else if (is_index(haddr[11:2], `MCS_IDX_IRQ_STATUS)) begin
        hrdata <= {27'h0000000, irq_status};
      end else if (is_index(haddr[11:2], `MCS_IDX_IRQ_ENABLE)) begin
        hrdata <= {27'h0000000, irq_enable};
      end else begin
        // unmapped and write-only addresses read zero
        hrdata <= 32'h00000000;
      end
    end
  end

  // clock select fields, ring enabled at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_req       <= CLK_SEL_RESET[`MCS_BIT_SLEEP];
      ring_osc_enable <= CLK_SEL_RESET[`MCS_BIT_RING_EN];
      source_override <= CLK_SEL_RESET[`MCS_BIT_OVERRIDE];
      rate_sel        <= CLK_SEL_RESET[`MCS_BIT_RATE_HI:`MCS_BIT_RATE_LO];
    end else if (wr_clk) begin
      sleep_req       <= hwdata[`MCS_BIT_SLEEP];
      ring_osc_enable <= hwdata[`MCS_BIT_RING_EN];
      source_override <= hwdata[`MCS_BIT_OVERRIDE];
      rate_sel        <= hwdata[`MCS_BIT_RATE_HI:`MCS_BIT_RATE_LO];
    end else if (wake_any && sleep_state != mcs_pkg::awake) begin
      // wakeup ends the sleep request
      sleep_req <= 1'b0;
    end
  end

  // ring gated first, then all oscillators
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_state <= mcs_pkg::awake;
    end else begin
      case (sleep_state)
        mcs_pkg::awake: begin
          if (core_power_control && sleep_req && !wake_any) begin
            sleep_state <= mcs_pkg::ring_gated;
          end
        end
        mcs_pkg::ring_gated: begin
          sleep_state <= wake_any ? mcs_pkg::awake : mcs_pkg::all_off;
        end
        mcs_pkg::all_off: begin
          if (wake_any) begin
            sleep_state <= mcs_pkg::awake;
          end
        end
        default: sleep_state <= mcs_pkg::awake;
      endcase
    end
  end

  // oscillator run controls
  assign ring_osc_run    = ring_osc_enable & (sleep_state == mcs_pkg::awake);
  assign crystal_osc_run = (sleep_state != mcs_pkg::all_off);

  // stopped oscillators deliver no edges
  assign ring_gated_tick    = ring_osc_tick & ring_osc_run;
  assign crystal_gated_tick = crystal_tick & crystal_osc_run;

  mcs_rate_divider u_rate (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .in_tick  (crystal_gated_tick),
    .rate_sel (rate_sel),
    .out_tick (rate_tick)
  );

  // override picks crystal rate or ring
  mcs_clock_switch u_switch (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .ring_tick    (ring_gated_tick),
    .crystal_tick (rate_tick),
    .want_crystal (source_override),
    .mcu_clk      (mcu_clk),
    .switching    (switching),
    .switch_done  (switch_done)
  );

  assign se0_need = low_speed ? `MCS_SE0_LOW_BITS : `MCS_SE0_FULL_BITS;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      se0_cnt <= 7'h00;
    end else if (!se0_level) begin
      se0_cnt <= 7'h00;
    end else if (bit_tick && se0_cnt < se0_need) begin
      se0_cnt <= se0_cnt + 7'h01;
    end
  end
  assign reset_event = se0_level & bit_tick & (se0_cnt == se0_need - 7'h01);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_seen <= 1'b0;
      nak_cnt    <= 32'h00000000;
    end else begin
      if (reset_event) begin
        reset_seen <= 1'b1;
      end else if (!se0_level) begin
        reset_seen <= 1'b0;
      end
      if (reset_seen && !se0_level) begin
        nak_cnt <= 32'(NAK_WINDOW_CYCLES);
      end else if (nak_cnt != 32'h00000000) begin
        nak_cnt <= nak_cnt - 32'h00000001;
      end
    end
  end
  assign setup_nak_window = (nak_cnt != 32'h00000000);

  // transition away from idle while suspended
  assign resume_event = global_suspend & j_prev & ~line_state_j;

  // line history for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      j_prev      <= 1'b1;
      ext_prev    <= 1'b0;
      stable_prev <= 1'b0;
    end else begin
      j_prev      <= line_state_j;
      ext_prev    <= external_event_flag;
      stable_prev <= phy_clocks_stable;
    end
  end

  // write-one clear, a new event wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_reset_flag <= WAKE_RESET[`MCS_BIT_BUS_RESET];
      resume_flag    <= WAKE_RESET[`MCS_BIT_RESUME];
      wake_spare     <= WAKE_RESET[7:3];
    end else begin
      bus_reset_flag <= reset_event | (bus_reset_flag & ~(wr_wake & hwdata[`MCS_BIT_BUS_RESET]));
      resume_flag    <= resume_event | (resume_flag & ~(wr_wake & hwdata[`MCS_BIT_RESUME]));
      if (wr_wake) begin
        wake_spare <= hwdata[7:3];
      end
    end
  end

  // external flag follows disk or pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      external_event_flag <= 1'b0;
    end else begin
      external_event_flag <= disk_interrupt_flag | pin_interrupt_line;
    end
  end

  assign wake_flags = {bus_reset_flag, resume_flag, external_event_flag};
  assign wake_any   = |(wake_flags & ~wakeup_mask_reg);

  // wakeup interrupt to the core
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wakeup_interrupt_input <= 1'b0;
    end else begin
      wakeup_interrupt_input <= wake_any;
    end
  end

  // sticky status, enable and clear registers
  assign irq_events = {switch_done, phy_clocks_stable & ~stable_prev,
                       external_event_flag & ~ext_prev, resume_event, reset_event};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= 5'h00;
    end else begin
      irq_status <= irq_events | (irq_status & ~(wr_iclr ? hwdata[4:0] : 5'h00));
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable <= `MCS_RST_IRQ_ENABLE;
    end else if (wr_ien) begin
      irq_enable <= hwdata[4:0];
    end
  end
  assign irq = |(irq_status & irq_enable);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_ring_off;
    !ring_osc_run && crystal_osc_run;
  endsequence
  sequence s_all_off;
    !ring_osc_run && !crystal_osc_run;
  endsequence

  property p_sleep_order;
    (sleep_state == mcs_pkg::awake && core_power_control && sleep_req && !wake_any && !wr_clk)
      ##1 !wake_any |-> s_ring_off ##1 s_all_off;
  endproperty
  a_sleep_order: assert property (p_sleep_order) else $error("oscillators not stopped in order");

  property p_ring_enable;
    wr_clk |=> ring_osc_enable == $past(hwdata[`MCS_BIT_RING_EN]);
  endproperty
  a_ring_enable: assert property (p_ring_enable) else $error("ring enable not written");

  property p_stable_mirror;
    (addr_ok && !hwrite && is_index(haddr[11:2], `MCS_IDX_CLOCK_SELECT))
      |=> hrdata[2] == $past(phy_clocks_stable) && hrdata[1:0] == 2'h0;
  endproperty
  a_stable_mirror: assert property (p_stable_mirror) else $error("clock valid bit wrong");

  property p_bus_reset_set;
    reset_event |=> bus_reset_flag;
  endproperty
  a_bus_reset_set: assert property (p_bus_reset_set) else $error("bus reset flag not set");

  property p_nak_window;
    (reset_seen && !se0_level) |=> setup_nak_window [*8];
  endproperty
  a_nak_window: assert property (p_nak_window) else $error("nak window not opened");

  property p_resume_set;
    (global_suspend && $past(line_state_j) && !line_state_j) |=> resume_flag;
  endproperty
  a_resume_set: assert property (p_resume_set) else $error("resume flag not set");

  property p_external;
    ##1 external_event_flag == $past(disk_interrupt_flag | pin_interrupt_line);
  endproperty
  a_external: assert property (p_external) else $error("external flag mismatch");

  property p_w1c;
    (wr_wake && hwdata[`MCS_BIT_RESUME] && !resume_event) |=> !resume_flag;
  endproperty
  a_w1c: assert property (p_w1c) else $error("resume flag not cleared");

  property p_wake_restart;
    (sleep_state == mcs_pkg::all_off && wake_any) |=> crystal_osc_run && sleep_state == mcs_pkg::awake;
  endproperty
  a_wake_restart: assert property (p_wake_restart) else $error("wakeup left oscillators off");

  property p_wake_irq;
    ##1 wakeup_interrupt_input == $past(|(wake_flags & ~wakeup_mask_reg));
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wakeup interrupt mismatch");
endmodule // mcs_clock_select_wakeup
`default_nettype wire

//--- tb/mcs_osc_model.sv
// oscillator and phy model facing the clock select block
`timescale 1ns/1ps
`default_nettype none
module mcs_osc_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ring_osc_run,
  input  wire logic crystal_osc_run,
  input  wire logic stable_req,
  output logic      ring_osc_tick,
  output logic      crystal_tick,
  output logic      phy_clocks_stable
);
  logic [1:0] ring_cnt; // ring edge every third cycle
  // stopped oscillators give no edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ring_cnt <= 2'h0;
      ring_osc_tick <= 1'b0;
      crystal_tick <= 1'b0;
    end else begin
      ring_cnt <= (ring_cnt == 2'h2) ? 2'h0 : ring_cnt + 2'h1;
      ring_osc_tick <= ring_osc_run && ring_cnt == 2'h2;
      crystal_tick <= crystal_osc_run && !crystal_tick;
    end
  end
  // phy clocks only valid while the crystal runs
  assign phy_clocks_stable = stable_req & crystal_osc_run;
endmodule // mcs_osc_model
`default_nettype wire

//--- tb/mcs_clock_select_wakeup_tb.sv
// self-checking bench for the clock select and wakeup block
`timescale 1ns/1ps
`default_nettype none
`include "mcs_regs.svh"
module mcs_clock_select_wakeup_tb;
  localparam logic [11:0] A_WU = {`MCS_IDX_WAKEUP_FLAGS, 2'h0};
  localparam logic [11:0] A_CS = {`MCS_IDX_CLOCK_SELECT, 2'h0};
  localparam logic [11:0] A_IE = {`MCS_IDX_IRQ_ENABLE, 2'h0};
  localparam logic [11:0] A_IS = {`MCS_IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] A_IC = {`MCS_IDX_IRQ_CLEAR, 2'h0};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpc, stab, disk, pin;
  logic se0, btick, lows, lj, gsus, rtick, xtick, rrun, xrun, mclk, nak, wkirq, irq, sreq;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, mask;
  logic [31:0] hwdata, hrdata, d;
  int          n_errors, checks, i, n;
  mcs_clock_select_wakeup #(.NAK_WINDOW_CYCLES(20)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .core_power_control(cpc),
    .phy_clocks_stable(stab), .wakeup_mask_reg(mask), .disk_interrupt_flag(disk), .pin_interrupt_line(pin),
    .se0_level(se0), .bit_tick(btick), .low_speed(lows), .line_state_j(lj), .global_suspend(gsus),
    .ring_osc_tick(rtick), .crystal_tick(xtick), .ring_osc_run(rrun), .crystal_osc_run(xrun),
    .mcu_clk(mclk), .setup_nak_window(nak), .wakeup_interrupt_input(wkirq), .irq(irq));
  mcs_osc_model osc (.hclk(hclk), .hresetn(hresetn), .ring_osc_run(rrun), .crystal_osc_run(xrun),
    .stable_req(sreq), .ring_osc_tick(rtick), .crystal_tick(xtick), .phy_clocks_stable(stab));
  // 25 MHz clock
  always #20 hclk = ~hclk;
  // verdict and end of run
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // compare a word
  task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // compare a bit
  task automatic check_bit(input string nm, input logic e, input logic s);
    check_word(nm, {31'h0, e}, {31'h0, s});
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      give_verdict();
    end
  endtask
  // one single word transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
  endtask
  // bit time pulses on the bus line
  task automatic ticks(input int k);
    repeat (k) begin
      btick <= 1'b1;
      @(posedge hclk);
      btick <= 1'b0;
      @(posedge hclk);
    end
  endtask
  // core clock toggles over 64 cycles once settled
  task automatic toggles(output int c);
    logic p;
    repeat (80) @(posedge hclk);
    @(negedge hclk);
    p = mclk;
    c = 0;
    repeat (64) begin
      @(negedge hclk);
      c += (mclk !== p) ? 1 : 0;
      p = mclk;
    end
    @(posedge hclk);
  endtask
  initial begin
    {hclk, hresetn, hsel, hwrite, cpc, sreq, disk, pin, se0, btick, lows, gsus} = 12'h000;
    {haddr, htrans, hsize, hwdata, mask, lj, n_errors, checks} = {12'h0, 2'h0, 3'h2, 32'h0, 3'h7, 1'b1, 64'h0};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(0, A_CS, 0, d); check_word("clock select", 32'h40, d);
    xfer(0, A_WU, 0, d); check_word("wakeup flags", 32'h00, d);
    xfer(0, 12'h3fc, 0, d); check_word("unmapped", 32'h00, d);
    check_bit("okay response", 1'b0, hresp);
    // poll the stable bit before further accesses
    sreq <= 1'b1;
    for (i = 0; i < 10 && d[2] !== 1'b1; i++) xfer(0, A_CS, 0, d);
    check_bit("stable poll", 1'b1, d[2]);
    xfer(1, A_CS, 32'h43, d); xfer(0, A_CS, 0, d); check_word("stable mirror", 32'h44, d);
    disk <= 1'b1; repeat (2) @(posedge hclk);
    xfer(0, A_WU, 0, d); check_word("disk ext", 32'h01, d);
    {disk, pin} <= 2'h1; repeat (2) @(posedge hclk);
    xfer(0, A_WU, 0, d); check_word("pin ext", 32'h01, d);
    pin <= 1'b0; repeat (2) @(posedge hclk);
    xfer(0, A_WU, 0, d); check_word("ext idle", 32'h00, d);
    // bus reset at the full and low speed thresholds
    for (n = 0; n < 2; n++) begin
      lows <= n[0]; se0 <= 1'b1;
      ticks(n ? 3 : 31); xfer(0, A_WU, 0, d); check_word("se0 short", 32'h00, d);
      ticks(1); xfer(0, A_WU, 0, d); check_word("se0 reset", 32'h04, d);
      se0 <= 1'b0;
      for (i = 0; i < 5 && nak !== 1'b1; i++) @(posedge hclk);
      for (i = 0; i < 40 && nak === 1'b1; i++) @(posedge hclk);
      check_word("nak cycles", 32'd20, i);
      xfer(1, A_WU, 32'h00, d); xfer(0, A_WU, 0, d); check_word("w0 keeps", 32'h04, d);
      xfer(1, A_WU, 32'h04, d); xfer(0, A_WU, 0, d); check_word("w1 clears", 32'h00, d);
    end
    xfer(0, A_IS, 0, d); check_word("irq status", 32'h0d, d);
    // switch to the crystal, firmware enabled the ring beforehand
    xfer(1, A_IE, 32'h10, d); xfer(1, A_CS, 32'h78, d);
    for (i = 0; i < 30 && irq !== 1'b1; i++) @(posedge hclk);
    check_bit("switch done", 1'b1, irq);
    xfer(1, A_IC, 32'h10, d); @(posedge hclk); check_bit("irq cleared", 1'b0, irq);
    for (n = 3; n >= 0; n--) begin
      xfer(1, A_CS, 32'h60 | (n << 3), d); toggles(i);
      check_bit("rate toggles", 1'b1, i >= (4 << n) - 1 && i <= (4 << n) + 1);
    end
    xfer(1, A_CS, 32'h40, d); toggles(i); check_bit("ring toggles", 1'b1, i >= 20 && i <= 22);
    // sleep with all wakeups masked, ring goes first
    cpc <= 1'b1; xfer(1, A_CS, 32'hc0, d);
    for (i = 0; i < 10 && rrun !== 1'b0; i++) @(negedge hclk);
    check_bit("ring gated", 1'b0, rrun); check_bit("crystal still", 1'b1, xrun);
    repeat (2) @(negedge hclk); check_bit("all off", 1'b0, xrun);
    @(posedge hclk);
    // resume wakes the core through its unmasked flag
    xfer(1, A_IE, 32'h02, d); mask <= 3'h5; gsus <= 1'b1; lj <= 1'b0;
    for (i = 0; i < 10 && !(rrun === 1'b1 && xrun === 1'b1); i++) @(posedge hclk);
    check_bit("ring back", 1'b1, rrun); check_bit("crystal back", 1'b1, xrun);
    check_bit("wake irq", 1'b1, wkirq); check_bit("resume irq", 1'b1, irq);
    cpc <= 1'b0; xfer(0, A_WU, 0, d); check_word("resume flag", 32'h02, d);
    mask <= 3'h7; repeat (3) @(posedge hclk); check_bit("wake masked", 1'b0, wkirq);
    xfer(1, A_IE, 32'h00, d); @(posedge hclk); check_bit("irq masked", 1'b0, irq);
    xfer(1, A_IE, 32'h02, d); xfer(1, A_IC, 32'h02, d); @(posedge hclk); check_bit("irq clr", 1'b0, irq);
    xfer(1, A_WU, 32'h02, d); xfer(0, A_WU, 0, d); check_word("resume clr", 32'h00, d);
    xfer(1, A_CS, 32'h00, d); @(posedge hclk); check_bit("ring off", 1'b0, rrun);
    xfer(1, A_CS, 32'h40, d); @(posedge hclk); check_bit("ring on", 1'b1, rrun);
    give_verdict();
  end
endmodule // mcs_clock_select_wakeup_tb
`default_nettype wire
